// file: hw/sync_if_pkg.sv
/*
 * Constants for the backplane synchronisation block: register map,
 * field layout, reset values, pulse timing and the enumerated modes.
 * Assumes a 32-bit AXI4-Lite register bus and eight trigger lines.
 */
package sync_if_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ROUTE_OUT = 8'h04;
    localparam logic [7:0] ADDR_ROUTE_IN = 8'h08;
    localparam logic [7:0] ADDR_CMD = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // ==========================================================
    // Control register fields
    localparam int CTRL_TB_OUT = 0;
    localparam int CTRL_TB_IN = 1;
    localparam int CTRL_RAW_OUT = 2;
    localparam int CTRL_CLK_OUT = 3;
    localparam int CTRL_START_OUT = 4;
    localparam int CTRL_SRC_LSB = 5;
    localparam int CTRL_MODE_LSB = 8;
    localparam int CTRL_W = 10;

    // Route register fields, one 3-bit line number each
    localparam int LINE_W = 3;
    localparam int FLD_TB = 0;
    localparam int FLD_RAW = 4;
    localparam int FLD_CLK = 8;
    localparam int FLD_START = 12;
    localparam int ROUTE_W = 15;

    // Command bits (write-one pulses) and status bits
    localparam int CMD_SW_TRIG = 0;
    localparam int CMD_SW_START = 1;
    localparam int CMD_ABORT = 2;
    localparam int ST_CONFLICT = 0;
    localparam int ST_ARMED = 1;
    localparam int ST_SAMPLING = 2;
    localparam int ST_DONE = 3;

    // ==========================================================
    // Reset values: every output off, routes on distinct lines
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] ROUTE_RST = 32'h0000_3210;

    // Raw trigger pulse width in timebase periods, two to three allowed
    localparam logic [1:0] RAW_PULSE_CYC = 2'h2;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Enumerations
    typedef enum logic [1:0] {
        trig_src_soft = 2'b00,
        trig_src_sync_raw = 2'b01,
        trig_src_sync_clocked = 2'b10
    } trig_src_t;

    typedef enum logic [1:0] {
        mode_post = 2'b00,
        mode_pre = 2'b01,
        mode_middle = 2'b10,
        mode_delay = 2'b11
    } acq_mode_t;

    typedef enum logic [1:0] {
        acq_idle = 2'b00,
        acq_armed = 2'b01,
        acq_sampling = 2'b10,
        acq_done = 2'b11
    } acq_state_t;

endpackage

// file: hw/system_sync_interface.sv
/*
 * Backplane synchronisation block: routes the shared timebase, the raw
 * and clocked triggers and the operation-start signal to and from eight
 * bidirectional trigger lines, and sequences the acquisition start/stop.
 * Assumes an AXI4-Lite master on aclk, a free-running timebase_clk that
 * is already the selected (local or shared) timebase, and an outside
 * clock mux steered by tb_use_shared and tb_in_line.
 */
`timescale 1ns/100ps

module system_sync_interface
    import sync_if_pkg::*;
#(
    parameter int LINES = 8
) (
    // Register bus clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timebases
    input wire logic timebase_clk,
    input wire logic local_timebase,
    // Backplane trigger lines
    input wire logic [LINES-1:0] trig_in,
    output logic [LINES-1:0] trig_out,
    output logic [LINES-1:0] trig_oe,
    // Timebase mux control
    output logic tb_use_shared,
    output logic [LINE_W-1:0] tb_in_line,
    // Acquisition core, timebase domain
    output logic acq_sample_en,
    output logic acq_trigger,
    output logic acq_op_start
);

    localparam int CFG_W = CTRL_W + 2 * ROUTE_W + 3;

    // ==========================================================
    // Functions
    function automatic logic [LINES-1:0] line_mask(input logic en,
            input logic [LINE_W-1:0] line);
        line_mask = en ? (LINES'(1) << line) : '0;
    endfunction

    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
            input logic [31:0] new_v, input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        merge_strb = res;
    endfunction

    // ==========================================================
    // Register bus side
    logic [31:0] ctrl_r, route_out_r, route_in_r;
    logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r, rdata_r;
    logic [3:0] w_strb_r;
    logic [1:0] bresp_r, rresp_r;
    logic sw_trig_tgl_r, sw_start_tgl_r, abort_tgl_r;
    logic [2:0] st_s1_r, st_s2_r, st_tb_r;
    logic do_write, conflict;
    logic [LINES-1:0] m_tb, m_raw, m_clk, m_st;

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign do_write = aw_held_r && w_held_r && !bvalid_r;

    // Address and data are taken in either order, then written together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Register writes and command toggles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= CTRL_RST;
            route_out_r <= ROUTE_RST;
            route_in_r <= ROUTE_RST;
            sw_trig_tgl_r <= 1'b0;
            sw_start_tgl_r <= 1'b0;
            abort_tgl_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (do_write) begin
                bvalid_r <= 1'b1;
                bresp_r <= RESP_OKAY;
                case (aw_addr_r)
                    ADDR_CTRL: begin
                        ctrl_r <= merge_strb(ctrl_r, w_data_r, w_strb_r)
                            & {{(32-CTRL_W){1'b0}}, {CTRL_W{1'b1}}};
                    end
                    ADDR_ROUTE_OUT: begin
                        route_out_r <= merge_strb(route_out_r, w_data_r,
                            w_strb_r) & {{(32-ROUTE_W){1'b0}},
                            {ROUTE_W{1'b1}}};
                    end
                    ADDR_ROUTE_IN: begin
                        route_in_r <= merge_strb(route_in_r, w_data_r,
                            w_strb_r) & {{(32-ROUTE_W){1'b0}},
                            {ROUTE_W{1'b1}}};
                    end
                    ADDR_CMD: begin
                        // Events cross as toggles so none is lost
                        if (w_strb_r[0]) begin
                            sw_trig_tgl_r <= sw_trig_tgl_r
                                ^ w_data_r[CMD_SW_TRIG];
                            sw_start_tgl_r <= sw_start_tgl_r
                                ^ w_data_r[CMD_SW_START];
                            abort_tgl_r <= abort_tgl_r
                                ^ w_data_r[CMD_ABORT];
                        end
                    end
                    ADDR_STATUS: begin
                        bresp_r <= RESP_OKAY; // Read-only, write ignored
                    end
                    default: begin
                        bresp_r <= RESP_SLVERR;
                    end
                endcase
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Same priority as the line drivers, for the status flag
    assign m_tb = line_mask(ctrl_r[CTRL_TB_OUT],
        route_out_r[FLD_TB +: LINE_W]);
    assign m_raw = line_mask(ctrl_r[CTRL_RAW_OUT],
        route_out_r[FLD_RAW +: LINE_W]);
    assign m_clk = line_mask(ctrl_r[CTRL_CLK_OUT],
        route_out_r[FLD_CLK +: LINE_W]);
    assign m_st = line_mask(ctrl_r[CTRL_START_OUT],
        route_out_r[FLD_START +: LINE_W]);
    assign conflict = |((m_tb & m_raw) | ((m_tb | m_raw) & m_clk)
        | ((m_tb | m_raw | m_clk) & m_st));

    // Sequencer state back from the timebase domain
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_s1_r <= 3'h0;
            st_s2_r <= 3'h0;
        end else begin
            st_s1_r <= st_tb_r;
            st_s2_r <= st_s1_r;
        end
    end

    // Read channel, answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CTRL: rdata_r <= ctrl_r;
                ADDR_ROUTE_OUT: rdata_r <= route_out_r;
                ADDR_ROUTE_IN: rdata_r <= route_in_r;
                ADDR_CMD: rdata_r <= 32'h0000_0000;
                ADDR_STATUS: begin
                    rdata_r <= 32'h0000_0000;
                    rdata_r[ST_CONFLICT] <= conflict;
                    rdata_r[ST_ARMED] <= st_s2_r[0];
                    rdata_r[ST_SAMPLING] <= st_s2_r[1];
                    rdata_r[ST_DONE] <= st_s2_r[2];
                end
                default: begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Clock mux steering stays in the bus domain: it picks the clock
    assign tb_use_shared = ctrl_r[CTRL_TB_IN];
    assign tb_in_line = route_in_r[FLD_TB +: LINE_W];

    // ==========================================================
    // Timebase domain
    logic trst_s1_r, trst_s2_r;
    logic [CFG_W-1:0] cfg_s1_r, cfg_s2_r;
    logic [2:0] tgl_d_r;
    logic [LINES-1:0] ln_s1_r, ln_s2_r, ln_s3_r;
    logic [LINES-1:0] tm_tb, tm_raw, tm_clk, tm_st, tb_line_r;
    logic [LINES-1:0] line_out_r, line_oe_r;
    logic [CTRL_W-1:0] c_ctrl;
    logic [ROUTE_W-1:0] c_rout, c_rin;
    logic [2:0] c_tgl, tgl_evt;
    trig_src_t src;
    acq_mode_t mode;
    acq_state_t state_r;
    logic raw_edge_r, clk_edge, start_edge, pre_like;
    logic trig_evt, start_evt, trig_acc, start_acc;
    logic [1:0] raw_cnt_r, start_cnt_r;
    logic raw_out_r, clk_out_r, start_out_r;
    logic tb_armed, tb_sampling, tb_done;

    // Reset release into the timebase domain
    always_ff @(posedge timebase_clk) begin
        trst_s1_r <= aresetn;
        trst_s2_r <= trst_s1_r;
    end

    // Settings are quasi-static; change routing only while idle
    always_ff @(posedge timebase_clk) begin
        if (!trst_s2_r) begin
            cfg_s1_r <= '0;
            cfg_s2_r <= '0;
            tgl_d_r <= 3'h0;
        end else begin
            cfg_s1_r <= {abort_tgl_r, sw_start_tgl_r, sw_trig_tgl_r,
                route_in_r[ROUTE_W-1:0], route_out_r[ROUTE_W-1:0],
                ctrl_r[CTRL_W-1:0]};
            cfg_s2_r <= cfg_s1_r;
            tgl_d_r <= c_tgl;
        end
    end

    assign c_ctrl = cfg_s2_r[CTRL_W-1:0];
    assign c_rout = cfg_s2_r[CTRL_W +: ROUTE_W];
    assign c_rin = cfg_s2_r[CTRL_W+ROUTE_W +: ROUTE_W];
    assign c_tgl = cfg_s2_r[CFG_W-1 -: 3];
    assign tgl_evt = c_tgl ^ tgl_d_r;
    assign src = trig_src_t'(c_ctrl[CTRL_SRC_LSB +: 2]);
    assign mode = acq_mode_t'(c_ctrl[CTRL_MODE_LSB +: 2]);
    assign pre_like = (mode == mode_pre) || (mode == mode_middle);

    // All eight lines pass two flip-flops, a third for edge history
    always_ff @(posedge timebase_clk) begin
        if (!trst_s2_r) begin
            ln_s1_r <= '0;
            ln_s2_r <= '0;
            ln_s3_r <= '0;
        end else begin
            ln_s1_r <= trig_in;
            ln_s2_r <= ln_s1_r;
            ln_s3_r <= ln_s2_r;
        end
    end

    // Raw input gets one extra stage; clocked input does not, which
    // removes its one-clock lag so both land on the master's edge
    always_ff @(posedge timebase_clk) begin
        if (!trst_s2_r) begin
            raw_edge_r <= 1'b0;
        end else begin
            raw_edge_r <= ln_s2_r[c_rin[FLD_RAW +: LINE_W]]
                && !ln_s3_r[c_rin[FLD_RAW +: LINE_W]];
        end
    end

    assign clk_edge = ln_s2_r[c_rin[FLD_CLK +: LINE_W]]
        && !ln_s3_r[c_rin[FLD_CLK +: LINE_W]];
    assign start_edge = ln_s2_r[c_rin[FLD_START +: LINE_W]]
        && !ln_s3_r[c_rin[FLD_START +: LINE_W]];

    // Trigger and start source selection
    always_comb begin
        case (src)
            trig_src_sync_raw: begin
                trig_evt = raw_edge_r;
                start_evt = tgl_evt[CMD_SW_START];
            end
            trig_src_sync_clocked: begin
                trig_evt = clk_edge;
                start_evt = start_edge;
            end
            default: begin
                trig_evt = tgl_evt[CMD_SW_TRIG];
                start_evt = tgl_evt[CMD_SW_START];
            end
        endcase
    end

    assign trig_acc = trig_evt && ((state_r == acq_armed)
        || (state_r == acq_sampling && pre_like));
    assign start_acc = start_evt
        && (state_r == acq_idle || state_r == acq_done);

    // Acquisition sequencer; middle mode post-samples belong to the core
    always_ff @(posedge timebase_clk) begin
        if (!trst_s2_r) begin
            state_r <= acq_idle;
        end else if (tgl_evt[CMD_ABORT]) begin
            state_r <= acq_idle;
        end else begin
            case (state_r)
                acq_idle, acq_done: begin
                    if (start_acc) begin
                        state_r <= pre_like ? acq_sampling : acq_armed;
                    end
                end
                acq_armed: begin
                    if (trig_acc) begin
                        state_r <= acq_sampling;
                    end
                end
                acq_sampling: begin
                    if (trig_acc) begin
                        state_r <= acq_done;
                    end
                end
                default: begin
                    state_r <= acq_idle;
                end
            endcase
        end
    end

    assign tb_armed = (state_r == acq_armed);
    assign tb_sampling = (state_r == acq_sampling);
    assign tb_done = (state_r == acq_done);

    // Pulse stretchers for raw trigger and operation start outputs
    always_ff @(posedge timebase_clk) begin
        if (!trst_s2_r) begin
            raw_cnt_r <= 2'h0;
            raw_out_r <= 1'b0;
            clk_out_r <= 1'b0;
            start_cnt_r <= 2'h0;
            start_out_r <= 1'b0;
        end else begin
            raw_cnt_r <= trig_acc ? RAW_PULSE_CYC
                : (raw_cnt_r != 2'h0 ? raw_cnt_r - 2'h1 : 2'h0);
            raw_out_r <= trig_acc || (raw_cnt_r > 2'h1);
            clk_out_r <= raw_out_r;
            start_cnt_r <= (start_acc && pre_like) ? RAW_PULSE_CYC
                : (start_cnt_r != 2'h0 ? start_cnt_r - 2'h1 : 2'h0);
            start_out_r <= (start_acc && pre_like)
                || (start_cnt_r > 2'h1);
        end
    end

    // Line ownership: timebase, raw, clocked, start in falling priority
    assign tm_tb = line_mask(c_ctrl[CTRL_TB_OUT], c_rout[FLD_TB +: LINE_W]);
    assign tm_raw = line_mask(c_ctrl[CTRL_RAW_OUT],
        c_rout[FLD_RAW +: LINE_W]) & ~tm_tb;
    assign tm_clk = line_mask(c_ctrl[CTRL_CLK_OUT],
        c_rout[FLD_CLK +: LINE_W]) & ~(tm_tb | tm_raw);
    assign tm_st = line_mask(c_ctrl[CTRL_START_OUT],
        c_rout[FLD_START +: LINE_W]) & ~(tm_tb | tm_raw | tm_clk);

    // Registered line drivers; a slave leaves all enables off
    always_ff @(posedge timebase_clk) begin
        if (!trst_s2_r) begin
            tb_line_r <= '0;
            line_out_r <= '0;
            line_oe_r <= '0;
        end else begin
            tb_line_r <= tm_tb;
            line_out_r <= (tm_raw & {LINES{raw_out_r}})
                | (tm_clk & {LINES{clk_out_r}})
                | (tm_st & {LINES{start_out_r}});
            line_oe_r <= tm_raw | tm_clk | tm_st;
        end
    end

    // Timebase is a clock, so it is gated straight through, not retimed
    assign trig_out = line_out_r | (tb_line_r & {LINES{local_timebase}});
    assign trig_oe = line_oe_r | tb_line_r;

    // Acquisition core strobes
    always_ff @(posedge timebase_clk) begin
        if (!trst_s2_r) begin
            acq_sample_en <= 1'b0;
            acq_trigger <= 1'b0;
            acq_op_start <= 1'b0;
            st_tb_r <= 3'h0;
        end else begin
            acq_sample_en <= tb_sampling;
            acq_trigger <= trig_acc;
            acq_op_start <= start_acc && pre_like;
            st_tb_r <= {tb_done, tb_sampling, tb_armed};
        end
    end

endmodule

// file: tb/sync_partner.sv
/* Behavioural master module on lines 1 to 3 of the trigger bus.
   Assumes requests arrive as one-cycle levels on its own clock. */
`timescale 1ns/100ps
// =====
// Partner
module sync_partner (
    // Timebase and requests
    input wire logic tclk,
    input wire logic en,
    input wire logic go_trig,
    input wire logic go_start,
    // Line drive
    output logic [7:0] p_out,
    output logic [7:0] p_oe
);
    logic [1:0] tw = 2'h0;
    logic [1:0] sw = 2'h0;
    logic td = 1'b0;
    // Drives only its own distinct lines while acting as master
    assign p_oe = en ? 8'h0e : 8'h00;
    // Raw pulse two cycles; clocked copy one cycle behind
    always_ff @(posedge tclk) begin
        tw <= go_trig ? 2'h2 : (tw != 2'h0 ? tw - 2'h1 : 2'h0);
        sw <= go_start ? 2'h2 : (sw != 2'h0 ? sw - 2'h1 : 2'h0);
        td <= tw != 2'h0;
    end
    assign p_out = {4'h0, sw != 2'h0, td, tw != 2'h0, 1'b0};
endmodule

// file: tb/system_sync_interface_checker.sv
/* Bus handshake and timebase pulse checks for the sync block.
   Assumes it is bound to the block and sees only its ports. */
`timescale 1ns/100ps
// =====
// Checker
module system_sync_interface_checker (
    // Bus side
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timebase side
    input wire logic timebase_clk,
    input wire logic [7:0] trig_oe,
    input wire logic acq_sample_en,
    input wire logic acq_trigger,
    input wire logic acq_op_start
);
    // Write and read answers, and how long they stand
    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_bresp_stands: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_stands: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_aw_refused: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_ar_refused: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    // Pulses of the acquisition core are single timebase cycles, and a start brings sampling
    a_trig_single: assert property (@(posedge timebase_clk)
        disable iff (!aresetn) acq_trigger |=> !acq_trigger)
        else $error("trigger pulse too long");
    a_start_single: assert property (@(posedge timebase_clk)
        disable iff (!aresetn) acq_op_start |=> !acq_op_start)
        else $error("start pulse too long");
    a_start_samples: assert property (@(posedge timebase_clk)
        disable iff (!aresetn) $rose(acq_op_start) |-> ##[0:2] acq_sample_en)
        else $error("start without sampling");
    // Reset reaches the line drivers through two flops, so allow four edges
    a_oe_quiet: assert property (@(posedge timebase_clk)
        (!aresetn) [*4] |-> trig_oe == 8'h00) else $error("line driven in reset");
endmodule
bind system_sync_interface system_sync_interface_checker
    i_system_sync_interface_checker (.*);

// file: tb/system_sync_interface_tb.sv
/* Register-level bench for the sync block with one partner module.
   Assumes lines are pulled up when nobody drives them. */
`timescale 1ns/100ps
// =====
// Bench
module system_sync_interface_tb;
    import sync_if_pkg::*;
    logic aclk = 0, aresetn = 0, timebase_clk = 0, local_timebase = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, p_en = 0, p_tr = 0, p_st = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, tb_use_shared;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [7:0] trig_out, trig_oe, p_out, p_oe;
    logic acq_sample_en, acq_trigger, acq_op_start;
    logic [LINE_W-1:0] tb_in_line;
    logic [1:0] pat [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
    int n_fail = 0, comparisons = 0, t, t1;
    // Pull-up wins only where no party drives
    wire [7:0] trig_in = (trig_oe & trig_out) | (p_oe & p_out)
        | ~(trig_oe | p_oe);
    wire [10:0] obs = {acq_op_start, acq_trigger, acq_sample_en, trig_in};
    always #5 aclk = ~aclk;
    always #6 timebase_clk = ~timebase_clk;
    always #8 local_timebase = ~local_timebase;
    system_sync_interface i_system_sync_interface (.*);
    sync_partner i_sync_partner (.tclk(timebase_clk), .en(p_en),
        .go_trig(p_tr), .go_start(p_st), .p_out(p_out), .p_oe(p_oe));
    // =====
    // Tasks
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task finish_test;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task hang;
        chk("wait", 0, 1);
        finish_test;
    endtask
    // One access; ready is looked at mid-cycle, where it is settled
    task automatic acc(input bit we, input logic [7:0] a, input logic [31:0] d);
        bit aw, w, ar, dn;
        int n;
        @(posedge aclk);
        if (we) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1;
            s_axi_wvalid <= 1;
            s_axi_bready <= 1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1;
            s_axi_rready <= 1;
        end
        for (n = 0; n < 40; n++) begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            ar = s_axi_arvalid && s_axi_arready;
            dn = we ? s_axi_bvalid : s_axi_rvalid;
            rd = s_axi_rdata;
            rs = we ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 0;
            if (w) s_axi_wvalid <= 0;
            if (ar) s_axi_arvalid <= 0;
            if (dn) begin
                s_axi_bready <= 0;
                s_axi_rready <= 0;
                break;
            end
        end
        if (n == 40) hang;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        acc(0, a, 0);
        chk("rdata", rd, e);
    endtask
    // Waits on a timebase-side level; t counts the cycles it took
    task automatic wt(input int b, input logic v, output int t);
        for (t = 0; t < 80 && obs[b] !== v; t++) @(negedge timebase_clk);
        if (t == 80) hang;
    endtask
    task pulse(input bit s);
        @(posedge timebase_clk);
        if (s) p_st <= 1;
        else p_tr <= 1;
        @(posedge timebase_clk);
        p_st <= 0;
        p_tr <= 0;
    endtask
    // =====
    // Sequence
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        rchk(ADDR_CTRL, CTRL_RST);
        rchk(ADDR_ROUTE_OUT, ROUTE_RST);
        rchk(ADDR_ROUTE_IN, ROUTE_RST);
        rchk(8'h20, 0);
        chk("rresp", rs, RESP_SLVERR);
        acc(1, 8'h20, 1);
        chk("bresp", rs, RESP_SLVERR);
        acc(1, ADDR_ROUTE_IN, 32'h7654);
        rchk(ADDR_ROUTE_IN, 32'h7654);
        @(negedge aclk);
        chk("tb_in_line", tb_in_line, 4);
        acc(1, ADDR_ROUTE_IN, ROUTE_RST);
        // Timebase master: only the timebase line is driven
        acc(1, ADDR_CTRL, 32'h3);
        repeat (6) @(negedge timebase_clk);
        chk("tb_shared", tb_use_shared, 1);
        #1; // Off the toggle instant
        chk("tb_line", trig_in[0], local_timebase);
        chk("oe", trig_oe, 8'h01);
        // Pre-trigger master on software start and trigger
        acc(1, ADDR_CTRL, 32'h11c);
        acc(1, ADDR_CMD, 2);
        wt(3, 1, t);
        wt(3, 0, t);
        chk("start_w", t, 2);
        wt(8, 1, t);
        acc(1, ADDR_CMD, 1);
        wt(1, 1, t);
        for (int i = 0; i < 4; i++) begin
            chk("raw_clk", obs[2:1], pat[i]);
            @(negedge timebase_clk);
        end
        wt(8, 0, t);
        // Slave on the raw trigger line, post mode
        acc(1, ADDR_CMD, 4);
        acc(1, ADDR_CTRL, 32'h20);
        repeat (4) @(negedge timebase_clk);
        chk("oe_off", trig_oe, 0);
        @(posedge timebase_clk);
        p_en <= 1;
        acc(1, ADDR_CMD, 2);
        repeat (6) @(negedge timebase_clk);
        pulse(0);
        wt(1, 1, t);
        wt(9, 1, t1);
        wt(8, 1, t);
        // Slave on clocked trigger and shared start, pre mode
        acc(1, ADDR_CMD, 4);
        acc(1, ADDR_CTRL, 32'h140);
        acc(1, ADDR_CMD, 2);
        repeat (8) @(negedge timebase_clk);
        chk("soft_start", acq_sample_en, 0);
        pulse(1);
        wt(10, 1, t);
        wt(8, 1, t);
        pulse(0);
        wt(1, 1, t);
        wt(9, 1, t);
        chk("latency", t, t1);
        wt(8, 0, t);
        // Two outputs routed to one line are flagged
        @(posedge timebase_clk);
        p_en <= 0;
        acc(1, ADDR_ROUTE_OUT, 32'h3110);
        acc(1, ADDR_CTRL, 32'h0c);
        acc(0, ADDR_STATUS, 0);
        chk("conflict", rd[ST_CONFLICT], 1);
        finish_test;
    end
endmodule
